// ===== hw/can_rx_overwrite_autobaud.v
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "can_rx_ovw_regs.vh"

module can_rx_overwrite_autobaud (
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite slave
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Frames from the protocol engine
   input  wire        rx_frame_valid,
   input  wire [10:0] rx_frame_id,
   input  wire [31:0] rx_frame_data,
   // Error events from the protocol engine
   input  wire        rx_err_inc1,
   input  wire        rx_err_inc8,
   input  wire        tx_err_inc8,
   // Bit streams
   input  wire        can_tx_core,
   output reg         can_rx_core,
   input  wire        can_rx_pin,
   output reg         can_tx_pin,
   output wire        bus_enable
);

   ////////////////////////////////////////////////////////////////////////
   // Storage
   reg  [15:1] txrx;           // tx_rx_select per center
   reg  [15:1] transmit_inhibit;            // transmit_inhibit
   reg  [15:1] du;             // data_unread
   reg  [15:1] rrp;            // remote_reply_pending
   reg  [15:1] oe;             // overwrite_enable
   reg  [15:1] row;            // receive_overwrite_flag, raw
   reg  [10:0] arb   [1:15];   // Arbitration values
   reg  [31:0] data  [1:15];   // Payload words
   reg  [31:0] shadow_data;    // Center 15 shadow payload
   reg  [10:0] shadow_id;      // Center 15 shadow identifier
   reg         shadow_full;    // Shadow holds unread frame
   reg         sw_init_hold;   // Bus activity stopped
   reg         autobaud;       // Listen-only loopback
   reg  [7:0]  tx_error_count; // Transmit error counter
   reg  [7:0]  rx_error_count; // Receive error counter
   reg         rx_meta;        // Pin synchroniser stage 1
   reg         rx_sync;        // Pin synchroniser stage 2
   // Center zero does not exist; slot 0 of each bank is unmapped
   integer     i;              // Placement search index
   integer     j;              // Reset loop index, kept apart from i

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Byte-lane merge of a write into an old word
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer      b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
               merge[b*8 +: 8] = nw[b*8 +: 8];
            end
         end
      end
   endfunction

   // Saturating counter step
   function [7:0] sat_add;
      input [7:0] cnt;
      input [7:0] inc;
      reg   [8:0] sum;
      begin
         sum = {1'b0, cnt} + {1'b0, inc};
         sat_add = sum[8] ? 8'hFF : sum[7:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake, one write and one read at a time
   // A second write waits until the master has taken the answer
   wire        wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   wire        rd_go = s_axi_arvalid & ~s_axi_rvalid;
   wire [3:0]  wr_idx = s_axi_awaddr[5:2];
   wire [3:0]  rd_idx = s_axi_araddr[5:2];
   wire [31:0] wd = s_axi_wdata;
   wire [3:0]  ws = s_axi_wstrb;

   // Address and data are taken together in the same edge
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = rd_go;
   assign bus_enable    = ~sw_init_hold;

   // Decoded write targets
   wire wr_ctrl = wr_go & (s_axi_awaddr[7:6] == 2'h0) & (wr_idx != 4'h0);
   wire wr_arb  = wr_go & (s_axi_awaddr[7:6] == 2'h1) & (wr_idx != 4'h0);
   wire wr_data = wr_go & (s_axi_awaddr[7:6] == 2'h3) & (wr_idx != 4'h0);
   wire wr_cctl = wr_go & (s_axi_awaddr == `CAN_CONTROL_ADDR);
   wire wr_txe  = wr_go & (s_axi_awaddr == `TX_ERR_ADDR);
   wire wr_rxe  = wr_go & (s_axi_awaddr == `RX_ERR_ADDR);
   wire wr_hit  = wr_ctrl | wr_arb | wr_data | wr_cctl | wr_txe | wr_rxe
                  | (wr_go & (s_axi_awaddr == `CAN_STATUS_ADDR));
   // Soft reset only when its byte lane is written with a one
   wire soft_rst = wr_cctl & ws[0] & wd[`CTL_SRST];
   // Arbitration write merged as a word, then cut to the 11 id bits
   wire [31:0] arb_merged = merge({21'h000000, arb[wr_idx]}, wd, ws);

   ////////////////////////////////////////////////////////////////////////
   // Frame placement search
   wire [15:1] busy = du | rrp;
   wire        frame_ok = rx_frame_valid & ~sw_init_hold;
   reg  [15:1] cand;          // Centers able to take the frame
   reg  [3:0]  sel;           // Lowest candidate
   reg         sel_hit;       // Any candidate at all

   // Lowest-numbered eligible receive center wins
   always @* begin
      sel     = 4'h0;
      sel_hit = 1'b0;
      for (i = 1; i <= 15; i = i + 1) begin
         // Center 15 ignores busy; the shadow absorbs busy cases
         cand[i] = ~txrx[i] & (arb[i] == rx_frame_id) &
                   ((i == 15) | ~busy[i] | oe[i]);
      end
      for (i = 15; i >= 1; i = i - 1) begin
         if (cand[i]) begin
            sel     = i[3:0];
            sel_hit = 1'b1;
         end
      end
   end

   // Center 15 picks main registers or shadow from its busy flags
   wire store   = frame_ok & sel_hit;
   wire to15    = store & (sel == 4'hF);
   wire main15  = to15 & ~busy[15];
   wire shad_ld = to15 & busy[15] & (~shadow_full | oe[15]);
   // Drain only when no frame heads for center 15 this edge
   wire drain   = shadow_full & ~busy[15] & ~to15;

   ////////////////////////////////////////////////////////////////////////
   // Center registers and shadow
   always @(posedge aclk) begin
      if (!aresetn) begin
         txrx        <= 15'h0000;
         transmit_inhibit         <= 15'h0000;
         du          <= 15'h0000;
         rrp         <= 15'h0000;
         oe          <= 15'h0000;
         row         <= 15'h0000;
         shadow_full <= 1'b0;
         shadow_data <= 32'h00000000;
         shadow_id   <= 11'h000;
         for (j = 1; j <= 15; j = j + 1) begin
            arb[j]  <= 11'h000;
            data[j] <= 32'h00000000;
         end
      end else begin
         // Software center writes first, hardware sets later win; soft reset comes last and wins
         if (wr_ctrl & ws[0]) begin
            // Inhibit only moves while transmit is selected
            if (txrx[wr_idx]) begin
               transmit_inhibit[wr_idx] <= wd[`CC_TIH];
            end
            txrx[wr_idx] <= wd[`CC_TXRX];
            du[wr_idx]   <= wd[`CC_DU];
            rrp[wr_idx]  <= wd[`CC_RRP];
            oe[wr_idx]   <= wd[`CC_OE];
            row[wr_idx]  <= wd[`CC_ROW];
         end
         if (wr_arb) begin
            arb[wr_idx] <= arb_merged[10:0];
         end
         if (wr_data) begin
            data[wr_idx] <= merge(data[wr_idx], wd, ws);
         end
         // Frame into a normal center or center 15 main registers
         if (store & (sel != 4'hF)) begin
            data[sel] <= rx_frame_data;
            du[sel]   <= 1'b1;
            // Only a store into a busy center (unread or reply pending) raises the flag
            if (busy[sel]) begin
               row[sel] <= 1'b1;
            end
         end
         if (main15) begin
            data[15] <= rx_frame_data;
            du[15]   <= 1'b1;
         end
         // Shadow load; flag only if unread shadow is replaced
         if (shad_ld) begin
            shadow_data <= rx_frame_data;
            shadow_id   <= rx_frame_id;
            shadow_full <= 1'b1;
            if (shadow_full) begin
               row[15] <= 1'b1;
            end
         end
         // Drain and load never meet: drain needs no frame for 15
         // Shadow drains into empty center 15
         if (drain) begin
            data[15]    <= shadow_data;
            du[15]      <= 1'b1;
            shadow_full <= 1'b0;
         end
         // Soft reset drops enables and the shadow
         if (soft_rst) begin
            oe          <= 15'h0000;
            shadow_full <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Global control and error counters
   // Saturation keeps a noisy bus from wrapping the count to zero
   wire cnt_on = ~sw_init_hold;

   // Error events only move the counters while the module listens on the bus; writes and soft reset load them at any time
   always @(posedge aclk) begin
      if (!aresetn) begin
         sw_init_hold   <= 1'b1;
         autobaud       <= 1'b0;
         tx_error_count <= `ERR_RESET;
         rx_error_count <= `ERR_RESET;
      end else begin
         // Hold and autobaud take byte lane 0 only
         if (wr_cctl & ws[0]) begin
            sw_init_hold <= wd[`CTL_HOLD];
            autobaud     <= wd[`CTL_AUTOBAUD];
         end
         if (cnt_on) begin
            if (rx_err_inc8) begin
               rx_error_count <= sat_add(rx_error_count, 8'h08);
            end else if (rx_err_inc1) begin
               rx_error_count <= sat_add(rx_error_count, 8'h01);
            end
            if (tx_err_inc8) begin
               tx_error_count <= sat_add(tx_error_count, 8'h08);
            end
         end
         // Writing the transmit counter loads both counters
         if (wr_txe & ws[0]) begin
            tx_error_count <= wd[7:0];
            rx_error_count <= wd[7:0];
         end
         if (wr_rxe & ws[0]) begin
            rx_error_count <= wd[7:0];
         end
         // Soft reset stops the bus and clears counters
         if (soft_rst) begin
            sw_init_hold   <= 1'b1;
            tx_error_count <= `ERR_RESET;
            rx_error_count <= `ERR_RESET;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin path with autobaud loopback
   // Two stages on the pin, one more edge for the core view
   always @(posedge aclk) begin
      if (!aresetn) begin
         rx_meta     <= 1'b1;
         rx_sync     <= 1'b1;
         can_rx_core <= 1'b1;
         can_tx_pin  <= 1'b1;
      end else begin
         rx_meta <= can_rx_pin;
         rx_sync <= rx_meta;
         // Own dominant bits still seen internally while listening
         can_rx_core <= autobaud ? (rx_sync & can_tx_core)
                                 : rx_sync;
         // Recessive while held or autobauding, so no error frames leak
         can_tx_pin  <= (autobaud | sw_init_hold) ? 1'b1
                                                  : can_tx_core;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status view
   // Either counter alone trips a threshold
   wire exceeded = (tx_error_count >= `ERR_EXCEED_LIMIT) |
                   (rx_error_count >= `ERR_EXCEED_LIMIT);
   wire passive  = (tx_error_count >= `ERR_PASSIVE_LIMIT) |
                   (rx_error_count >= `ERR_PASSIVE_LIMIT);
   // Stale inhibit on an overwrite-enabled receive center forces the flag high
   wire [15:1] row_view = row | (transmit_inhibit & ~txrx & oe);

   reg  [31:0] rd_word;
   reg         rd_ok;

   // Read decode; unmapped addresses answer an error
   // Reads have no side effects, so a repeated poll is harmless
   always @* begin
      rd_word = 32'h00000000;
      rd_ok   = 1'b1;
      if ((s_axi_araddr[7:6] == 2'h0) && (rd_idx != 4'h0)) begin
         rd_word = {26'h0000000, row_view[rd_idx], oe[rd_idx],
                    rrp[rd_idx], du[rd_idx], transmit_inhibit[rd_idx], txrx[rd_idx]};
      end else if ((s_axi_araddr[7:6] == 2'h1) && (rd_idx != 4'h0)) begin
         rd_word = {21'h000000, arb[rd_idx]};
      end else if ((s_axi_araddr[7:6] == 2'h3) && (rd_idx != 4'h0)) begin
         rd_word = data[rd_idx];
      end else begin
         case (s_axi_araddr)
            `CAN_CONTROL_ADDR: begin
               rd_word = {29'h00000000, autobaud, 1'b0, sw_init_hold};
            end
            `CAN_STATUS_ADDR: begin
               rd_word = {24'h000000, sw_init_hold, 4'h0, shadow_full,
                          passive, exceeded};
            end
            `TX_ERR_ADDR: begin
               rd_word = {24'h000000, tx_error_count};
            end
            `RX_ERR_ADDR: begin
               rd_word = {24'h000000, rx_error_count};
            end
            default: begin
               rd_ok = 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Response channels
   // Each answer stands until the master raises its ready
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= `RESP_OKAY;
         s_axi_rdata  <= 32'h00000000;
      end else begin
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

// ===== pkg/can_rx_ovw_regs.vh
// Operation
// - Centers 1-15 each own an overwrite_enable bit
// - Overwrite enabled stores frame despite data_unread
// - Replacing stored frame sets receive_overwrite_flag
// - Overwrite disabled: busy center takes no data
// - Inhibit left set reads overwrite flag 1 with overwrite enabled
// - transmit_inhibit writable only in transmit mode
// - Shared value fills lowest free center first
// - Overwrite disabled never sets overwrite flag
// - Empty center 15 stores frames directly
// - Busy center 15 routes frames to shadow
// - Shadow moves into center 15 when empty
// - Overwrite enabled replaces shadow, flags if unread
// - Empty shadow fills without setting flag
// - Center 15 flag means shadow replacement only
// - Overwrite disabled, shadow full: frame dropped
// - Autobaud bit 2 ANDs receive with transmit
// - Autobaud holds transmit pin recessive high
// - Listening errors count, threshold sets exceeded flag
// - Soft reset stops bus, sets hold, clears counters
// - Error counters zero on either reset
`ifndef CAN_RX_OVW_REGS_VH
`define CAN_RX_OVW_REGS_VH

// Register byte addresses
`define CTRL_BASE        8'h00
`define ARB_BASE         8'h40
`define DATA_BASE        8'hC0
`define CAN_CONTROL_ADDR 8'hA0
`define CAN_STATUS_ADDR  8'hA4
`define TX_ERR_ADDR      8'hA8
`define RX_ERR_ADDR      8'hAC

// Center control fields
`define CC_TXRX   0
`define CC_TIH    1
`define CC_DU     2
`define CC_RRP    3
`define CC_OE     4
`define CC_ROW    5

// can_control fields
`define CTL_HOLD     0
`define CTL_SRST     1
`define CTL_AUTOBAUD 2

// can_status fields
`define ST_EXCEEDED 0
`define ST_PASSIVE  1
`define ST_SHADOW   2
`define ST_HOLD     7

// Counter thresholds and reset values
`define ERR_EXCEED_LIMIT 8'h60
`define ERR_PASSIVE_LIMIT 8'h80
`define ERR_RESET        8'h00
`define CTL_RESET        8'h01

// Bus responses
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== tb/can_bus_node.sv
`timescale 1ns/1ps
////////////////////////////////////////
// Other nodes on the wire: open drain, recessive high
module can_bus_node (
   input  wire node_bit,   // Level the other nodes pull to
   input  wire can_tx_pin, // Our own driver
   output wire can_rx_pin  // Wire level seen by everyone
);
   // Dominant from any party wins; an unknown passes only while the other side is recessive
   assign can_rx_pin = node_bit & can_tx_pin;
endmodule

// ===== tb/can_rx_ovw_checker.sv
`timescale 1ns/1ps
////////////////////////////////////////
module can_rx_ovw_checker (
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awvalid,
   input wire        s_axi_wvalid,
   input wire        s_axi_awready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_arvalid,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire        can_rx_pin,
   input wire        can_rx_core,
   input wire        can_tx_pin,
   input wire        bus_enable
);
   // One domain, so clock and reset are stated once
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Bus answers come exactly one edge after the take
   a_write_answer:
   assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
      |=> s_axi_bvalid) else $error("write answer not next cycle");
   a_read_answer:
   assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
      else $error("read answer not next cycle");
   // Answers stand until the master accepts them
   a_resp_hold:
   assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write answer dropped");
   a_rdata_hold:
   assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read answer dropped");
   a_one_write:
   assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken while answer pending");
   a_resp_code:
   assert property (s_axi_bvalid |-> s_axi_bresp[0] == 1'b0)
      else $error("illegal write response");
   // Held module keeps the wire recessive
   a_hold_quiet:
   assert property (!bus_enable |=> can_tx_pin)
      else $error("transmit active during hold");
   // Loopback can only lower the receive bit, three edges late
   a_rx_high_src:
   assert property (can_rx_core |-> $past(can_rx_pin, 3))
      else $error("receive bit high without wire high");
   a_rx_dominant:
   assert property (!can_rx_pin |-> ##3 !can_rx_core)
      else $error("dominant wire bit lost");
endmodule

bind can_rx_overwrite_autobaud can_rx_ovw_checker chk (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .can_rx_pin, .can_rx_core, .can_tx_pin,
   .bus_enable);

// ===== tb/test_can_rx_overwrite_autobaud.sv
`timescale 1ns/1ps
`include "can_rx_ovw_regs.vh"
module test_can_rx_overwrite_autobaud;
   reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   reg  [7:0]  awaddr, araddr;
   reg  [31:0] wdata, cap_d;
   reg  [1:0]  cap_r;
   reg         fv, e1, e8, t8, tx_core, node_bit;
   reg  [10:0] fid;
   reg  [31:0] fdat, d [0:4];
   reg  [31:0] rnd;
   wire        awready, wready, bvalid, arready, rvalid, rx_core;
   wire        rx_pin, tx_pin, bus_en;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   integer     seed, i, n_errors, samples_checked;
   ////////////////////////////////////////
   can_rx_overwrite_autobaud uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .rx_frame_valid(fv), .rx_frame_id(fid),
      .rx_frame_data(fdat), .rx_err_inc1(e1), .rx_err_inc8(e8),
      .tx_err_inc8(t8), .can_tx_core(tx_core), .can_rx_core(rx_core),
      .can_rx_pin(rx_pin), .can_tx_pin(tx_pin), .bus_enable(bus_en));
   can_bus_node node (.node_bit(node_bit), .can_tx_pin(tx_pin),
      .can_rx_pin(rx_pin));
   // Free running clock
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // Expected center control word
   function [31:0] ctl(input tx, transmit_inhibit, du, oe, row);
      ctl = {26'h0, row, oe, 1'b0, du, transmit_inhibit, tx};
   endfunction
   // Byte address of slot x in a bank
   function [7:0] ad(input [7:0] b, input [3:0] x);
      ad = b + {2'b00, x, 2'b00};
   endfunction
   task end_of_test;
      begin
         $display("checked %0d errors %0d", samples_checked, n_errors);
         if (n_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task cmp(input [31:0] g, input [31:0] e);
      begin
         samples_checked = samples_checked + 1;
         if (g !== e) begin
            n_errors = n_errors + 1;
            $display("FAIL %0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   task cmp_pin(input g, input e);
      cmp({31'h0, g}, {31'h0, e});
   endtask
   // Bounded wait for a handshake; the rising edge after it is the take
   task hs(input [1:0] s);
      integer n;
      begin
         n = 0;
         do begin
            @(negedge aclk);
            n = n + 1;
            cap_d = rdata;
            cap_r = (s == 2'd1) ? bresp : rresp;
         end while ((s == 0 ? (awready & wready) : s == 1 ? bvalid
            : s == 2 ? arready : rvalid) !== 1'b1 && n < 64);
         if (n >= 64) begin
            n_errors = n_errors + 1;
            end_of_test;
         end
         @(posedge aclk);
      end
   endtask
   task wr(input [7:0] a, input [31:0] v);
      begin
         @(posedge aclk);
         awaddr <= a;
         wdata <= v;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         hs(0);
         awvalid <= 1'b0;
         wvalid <= 1'b0;
         // Ready comes late so the answer has to stand one cycle
         @(posedge aclk);
         bready <= 1'b1;
         hs(1);
         bready <= 1'b0;
      end
   endtask
   task rd(input [7:0] a);
      begin
         @(posedge aclk);
         araddr <= a;
         arvalid <= 1'b1;
         hs(2);
         arvalid <= 1'b0;
         @(posedge aclk);
         rready <= 1'b1;
         hs(3);
         rready <= 1'b0;
      end
   endtask
   // Read and compare one register
   task rc(input [7:0] a, input [31:0] e);
      begin
         rd(a);
         cmp(cap_d, e);
      end
   endtask
   // One frame from the protocol engine, a single cycle pulse
   task frame(input [10:0] id, input [31:0] v);
      begin
         @(posedge aclk);
         fv <= 1'b1;
         fid <= id;
         fdat <= v;
         @(posedge aclk);
         fv <= 1'b0;
      end
   endtask
   ////////////////////////////////////////
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {fv, e1, e8, t8, tx_core} = 5'h00;
      node_bit = 1'b1;
      {awaddr, araddr, wdata, fid, fdat} = 0;
      {n_errors, samples_checked} = 0;
      seed = 32'h76E8C5B3;
      for (i = 0; i < 5; i = i + 1)
         d[i] = $random(seed);
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rc(`CAN_STATUS_ADDR, 32'h80);
      rc(`TX_ERR_ADDR, 32'h0);
      rc(ad(`CTRL_BASE, 1), 32'h0);
      rd(8'h00);
      cmp(cap_r, `RESP_SLVERR);
      wr(8'h00, 32'h0);
      cmp(cap_r, `RESP_SLVERR);
      for (i = 1; i < 4; i = i + 1)
         wr(ad(`ARB_BASE, i), i < 3 ? 32'h0AB : 32'h155);
      wr(ad(`ARB_BASE, 15), 32'h2AA);
      wr(ad(`CTRL_BASE, 3), ctl(0, 0, 0, 1, 0));
      frame(11'h0AB, d[0]);
      wr(`CAN_CONTROL_ADDR, 32'h0);
      cmp(cap_r, `RESP_OKAY);
      // Shared value, overwrite off: fill lowest free, then drop
      for (i = 1; i < 4; i = i + 1)
         frame(11'h0AB, d[i]);
      rc(ad(`DATA_BASE, 1), d[1]);
      rc(ad(`DATA_BASE, 2), d[2]);
      rc(ad(`CTRL_BASE, 1), ctl(0, 0, 1, 0, 0));
      wr(ad(`CTRL_BASE, 1), 32'h0);
      frame(11'h0AB, d[4]);
      rc(ad(`DATA_BASE, 1), d[4]);
      rc(ad(`DATA_BASE, 2), d[2]);
      // Overwrite on: newest wins and is flagged
      frame(11'h155, d[1]);
      frame(11'h155, d[2]);
      rc(ad(`DATA_BASE, 3), d[2]);
      rc(ad(`CTRL_BASE, 3), ctl(0, 0, 1, 1, 1));
      // Clear unread, frame arrives, recheck shows unread again, so the data is reread
      wr(ad(`CTRL_BASE, 3), ctl(0, 0, 0, 1, 0));
      frame(11'h155, d[3]);
      rc(ad(`CTRL_BASE, 3), ctl(0, 0, 1, 1, 0));
      rc(ad(`DATA_BASE, 3), d[3]);
      // Inhibit only moves in transmit mode
      wr(ad(`CTRL_BASE, 4), ctl(0, 1, 0, 0, 0));
      rc(ad(`CTRL_BASE, 4), 32'h0);
      wr(ad(`CTRL_BASE, 4), ctl(1, 0, 0, 0, 0));
      wr(ad(`CTRL_BASE, 4), ctl(1, 1, 0, 0, 0));
      wr(ad(`CTRL_BASE, 4), ctl(0, 1, 0, 1, 0));
      rc(ad(`CTRL_BASE, 4), ctl(0, 1, 0, 1, 1));
      // Last center with its shadow, overwrite off
      frame(11'h2AA, d[1]);
      rc(ad(`DATA_BASE, 15), d[1]);
      frame(11'h2AA, d[2]);
      rc(`CAN_STATUS_ADDR, 32'h04);
      frame(11'h2AA, d[3]);
      rc(ad(`DATA_BASE, 15), d[1]);
      wr(ad(`CTRL_BASE, 15), 32'h0);
      rc(ad(`DATA_BASE, 15), d[2]);
      rc(ad(`CTRL_BASE, 15), ctl(0, 0, 1, 0, 0));
      // Overwrite on: flag only for a shadow replacement
      wr(ad(`CTRL_BASE, 15), ctl(0, 0, 1, 1, 0));
      frame(11'h2AA, d[4]);
      rc(ad(`CTRL_BASE, 15), ctl(0, 0, 1, 1, 0));
      frame(11'h2AA, d[0]);
      rc(ad(`CTRL_BASE, 15), ctl(0, 0, 1, 1, 1));
      rc(ad(`DATA_BASE, 15), d[2]);
      wr(ad(`CTRL_BASE, 15), ctl(0, 0, 0, 1, 0));
      rc(ad(`DATA_BASE, 15), d[0]);
      // Error events; +8 beats +1 in the same edge
      @(posedge aclk);
      {e1, e8} <= 2'b11;
      for (i = 0; i < 12; i = i + 1) begin
         t8 <= 1'b1;
         @(posedge aclk);
         {e1, e8} <= 2'b00;
      end
      t8 <= 1'b0;
      rc(`TX_ERR_ADDR, 32'h60);
      rc(`RX_ERR_ADDR, 32'h08);
      rc(`CAN_STATUS_ADDR, 32'h01);
      wr(`CAN_CONTROL_ADDR, 32'h02);
      rc(`CAN_STATUS_ADDR, 32'h80);
      rc(`TX_ERR_ADDR, 32'h0);
      rc(`RX_ERR_ADDR, 32'h0);
      rc(ad(`CTRL_BASE, 4), ctl(0, 1, 0, 0, 0));
      // Listening mode: random wire and core bits
      wr(`CAN_CONTROL_ADDR, 32'h05);
      wr(`CAN_CONTROL_ADDR, 32'h04);
      for (i = 0; i < 8; i = i + 1) begin
         @(posedge aclk);
         rnd = $random(seed);
         {node_bit, tx_core} <= rnd[1:0];
         repeat (5) @(negedge aclk);
         cmp_pin(tx_pin, 1'b1);
         cmp_pin(rx_core, node_bit & tx_core);
      end
      wr(`CAN_CONTROL_ADDR, 32'h0);
      tx_core <= 1'b0;
      node_bit <= 1'b1;
      repeat (5) @(negedge aclk);
      cmp_pin(tx_pin, 1'b0);
      cmp_pin(rx_core, 1'b0);
      end_of_test;
   end
endmodule
